// [shared/spp_pkg.sv]
package spp_pkg;

   // ****************************************
   // Word layout
   // ****************************************
   localparam int WORD_W = 24;
   localparam int ADDR_FLAG_POS = 23;
   localparam int ADDR_POS = 20;
   localparam logic [3:0] ADDR_B = 4'h1;
   localparam logic [3:0] ADDR_C = 4'h2;
   localparam logic [3:0] ADDR_D = 4'h3;
   localparam logic [3:0] ADDR_E = 4'h4;
   localparam logic [3:0] ADDR_G = 4'h5;
   localparam logic [23:0] WORD_RESET = 24'h000000;

   // Main-divider word.
   localparam int FIRST_POS = 0;
   localparam int SECOND_POS = 12;
   localparam int THIRD_POS = 16;
   localparam int FINC_STD_POS = 20;
   localparam int MAINDIV_ENH_POS = 0;
   localparam int FINC_ENH_POS = 18;
   // Charge-pump word.
   localparam int PUMP_POS = 0;
   localparam int PBOOST_POS = 8;
   localparam int IBOOST_POS = 10;
   localparam int KIND_POS = 14;
   // Auxiliary word.
   localparam int ENH_POS = 0;
   localparam int AUXDIV_POS = 1;
   localparam int FMODSEL_POS = 14;
   // Reference word.
   localparam int REFDIV_POS = 0;
   localparam int MPOST_POS = 12;
   localparam int APOST_POS = 14;
   localparam int MEN_POS = 16;
   localparam int AEN_POS = 17;
   // General word.
   localparam int VGA_POS = 0;
   localparam int OLDIV_POS = 7;
   localparam int OLEN_POS = 9;
   localparam int SYSMODE_POS = 10;
   localparam int SLEEP_POS = 11;

   localparam logic [3:0] OLDIV_BASE = 4'h6;
   localparam logic [4:0] FRAC_MODULUS_SELECT_STD_HI = 5'h08;
   localparam logic [4:0] FRAC_MODULUS_SELECT_STD_LO = 5'h05;

   // ****************************************
   // APB map
   // ****************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_AWORD = 8'h08;
   localparam logic [7:0] REG_BWORD = 8'h0c;
   localparam logic [7:0] REG_CWORD = 8'h10;
   localparam logic [7:0] REG_DWORD = 8'h14;
   localparam logic [7:0] REG_GWORD = 8'h18;
   localparam logic [7:0] REG_EWORD = 8'h1c;
   localparam logic CTRL_RESET = 1'b1;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_WAIT_SYNC = 2'b10
   } spp_state_t;

   typedef struct packed {
      logic enhanced;
      logic two_modulus;
      logic [17:0] main_divide_ratio;
      logic [11:0] first_ratio_count;
      logic [7:0] second_ratio_count;
      logic [3:0] third_ratio_count;
      logic [3:0] frac_increment;
      logic [4:0] frac_modulus;
      logic [7:0] pump_current_factor;
   } spp_main_t;

   typedef struct packed {
      logic [12:0] aux_divide_ratio;
      logic [11:0] ref_divide_ratio;
      logic [3:0] main_postscale;
      logic [3:0] aux_postscale;
      logic [3:0] offset_loop_div;
      logic [6:0] vga_power_level;
      logic digital_mode;
      logic driver_low_current;
      logic [1:0] proportional_boost;
      logic [3:0] integral_boost;
      logic [18:0] test_bits;
   } spp_cfg_t;

   typedef struct packed {
      logic xtal_osc_en;
      logic mclk_buf_en;
      logic control_en;
      logic ref_clk_buf_en;
      logic ref_input_buf_en;
      logic main_vco_input_en;
      logic aux_div_buf_en;
      logic main_pd_en;
      logic aux_pd_en;
      logic lock_detect_en;
      logic transmit_offset_en;
      logic modulator_en;
      logic vga_en;
   } spp_power_t;

endpackage

// [design/spp_serial_port.sv]
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module spp_serial_port
   import spp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic load_latch,
   input wire logic main_sync,
   output spp_main_t main_cfg,
   output spp_cfg_t misc_cfg,
   output spp_power_t power
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [1:0] clk_sync_reg, data_sync_reg, latch_sync_reg, msync_sync_reg;
   logic clk_prev_reg, latch_prev_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clk_sync_reg <= 2'h0;
         data_sync_reg <= 2'h0;
         latch_sync_reg <= 2'h3;
         msync_sync_reg <= 2'h0;
         clk_prev_reg <= 1'b0;
         latch_prev_reg <= 1'b1;
      end
      else
      begin
         clk_sync_reg <= {clk_sync_reg[0], ser_clk};
         data_sync_reg <= {data_sync_reg[0], ser_data};
         latch_sync_reg <= {latch_sync_reg[0], load_latch};
         msync_sync_reg <= {msync_sync_reg[0], main_sync};
         clk_prev_reg <= clk_sync_reg[1];
         latch_prev_reg <= latch_sync_reg[1];
      end
   end

   logic clk_rise, latch_rise, sync_on;
   assign clk_rise = clk_sync_reg[1] & ~clk_prev_reg;
   assign latch_rise = latch_sync_reg[1] & ~latch_prev_reg;
   assign sync_on = msync_sync_reg[1];

   // ****************************************
   // Shift register and address decode
   // ****************************************
   logic [WORD_W-1:0] shift_reg;
   logic port_en_reg;

   // Right shift puts the first bit at the bottom once 24 bits are in.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         shift_reg <= WORD_RESET;
      else if (clk_rise && !latch_sync_reg[1])
         shift_reg <= {data_sync_reg[1], shift_reg[WORD_W-1:1]};
   end

   logic load, hit_a, hit_b, hit_c, hit_d, hit_e, hit_g;
   logic [3:0] word_addr;
   assign load = latch_rise & port_en_reg;
   assign word_addr = shift_reg[ADDR_POS +: 4];
   // One flag bit marks the main-divider word, four bits mark the rest.
   assign hit_a = load & shift_reg[ADDR_FLAG_POS];
   assign hit_b = load & (word_addr == ADDR_B);
   assign hit_c = load & (word_addr == ADDR_C);
   assign hit_d = load & (word_addr == ADDR_D);
   assign hit_e = load & (word_addr == ADDR_E);
   assign hit_g = load & (word_addr == ADDR_G);

   // ****************************************
   // Word registers
   // ****************************************
   logic [22:0] a_hold_reg, a_work_reg;
   logic [7:0] pump_stage_reg, pump_work_reg;
   logic [1:0] kind_stage_reg, kind_work_reg;
   logic [5:0] boost_reg;
   logic [18:0] c_reg, e_reg;
   logic [17:0] d_reg;
   logic [11:0] g_reg;
   spp_state_t state_reg;

   // Unknown addresses fall through every branch and leave all words alone.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pump_stage_reg <= 8'h00;
         kind_stage_reg <= 2'h0;
         boost_reg <= 6'h00;
         c_reg <= 19'h00000;
         d_reg <= 18'h00000;
         g_reg <= 12'h000;
      end
      else if (hit_b)
      begin
         pump_stage_reg <= shift_reg[PUMP_POS +: 8];
         kind_stage_reg <= shift_reg[KIND_POS +: 2];
         boost_reg <= shift_reg[PBOOST_POS +: 6];
      end
      else if (hit_c)
         c_reg <= shift_reg[18:0];
      else if (hit_d)
         d_reg <= shift_reg[17:0];
      else if (hit_g)
         g_reg <= shift_reg[11:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         e_reg <= 19'h00000;
      else if (hit_d)
         e_reg <= 19'h00000;
      else if (hit_e)
         e_reg <= shift_reg[18:0];
   end

   // A main-divider word waits for the divider's own terminal count so
   // that a reload never breaks a divide cycle half way.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= ST_IDLE;
         a_hold_reg <= 23'h000000;
         a_work_reg <= 23'h000000;
         pump_work_reg <= 8'h00;
         kind_work_reg <= 2'h0;
      end
      else
      begin
         if (hit_a)
            a_hold_reg <= shift_reg[22:0];
         case (state_reg)
            ST_IDLE:
               if (hit_a)
                  state_reg <= ST_WAIT_SYNC;
            ST_WAIT_SYNC:
            begin
               if (sync_on && !hit_a)
               begin
                  a_work_reg <= a_hold_reg;
                  pump_work_reg <= pump_stage_reg;
                  kind_work_reg <= kind_stage_reg;
                  state_reg <= ST_IDLE;
               end
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Decoded outputs
   // ****************************************
   spp_main_t main_next;
   spp_cfg_t cfg_next;
   spp_power_t power_next;
   logic enh, sleep_ctl, ol_en, men, aen;
   assign enh = c_reg[ENH_POS];
   assign sleep_ctl = g_reg[SLEEP_POS];
   assign ol_en = g_reg[OLEN_POS];
   assign men = d_reg[MEN_POS];
   assign aen = d_reg[AEN_POS];

   always_comb
   begin
      main_next.enhanced = enh;
      main_next.two_modulus = kind_work_reg[0];
      main_next.pump_current_factor = pump_work_reg;
      main_next.first_ratio_count = a_work_reg[FIRST_POS +: 12];
      if (kind_work_reg[0])
      begin
         main_next.second_ratio_count = a_work_reg[SECOND_POS +: 8];
         main_next.third_ratio_count = 4'h0;
      end
      else
      begin
         main_next.second_ratio_count = {4'h0, a_work_reg[SECOND_POS +: 4]};
         main_next.third_ratio_count = a_work_reg[THIRD_POS +: 4];
      end
      if (enh)
      begin
         main_next.main_divide_ratio = a_work_reg[MAINDIV_ENH_POS +: 18];
         main_next.frac_increment = a_work_reg[FINC_ENH_POS +: 4];
         main_next.frac_modulus = c_reg[FMODSEL_POS +: 5];
      end
      else
      begin
         main_next.main_divide_ratio = 18'h00000;
         main_next.frac_increment = {1'b0, a_work_reg[FINC_STD_POS +: 3]};
         main_next.frac_modulus = c_reg[FMODSEL_POS] ? FRAC_MODULUS_SELECT_STD_HI : FRAC_MODULUS_SELECT_STD_LO;
      end
   end

   always_comb
   begin
      cfg_next.aux_divide_ratio = c_reg[AUXDIV_POS +: 13];
      cfg_next.ref_divide_ratio = d_reg[REFDIV_POS +: 12];
      cfg_next.main_postscale = 4'h1 << d_reg[MPOST_POS +: 2];
      cfg_next.aux_postscale = 4'h1 << d_reg[APOST_POS +: 2];
      cfg_next.offset_loop_div = OLDIV_BASE + {2'h0, g_reg[OLDIV_POS +: 2]};
      cfg_next.vga_power_level = g_reg[VGA_POS +: 7];
      cfg_next.digital_mode = g_reg[SYSMODE_POS];
      cfg_next.driver_low_current = ~g_reg[SYSMODE_POS];
      cfg_next.proportional_boost = boost_reg[1:0];
      cfg_next.integral_boost = boost_reg[5:2];
      cfg_next.test_bits = e_reg;
   end

   always_comb
   begin
      power_next.xtal_osc_en = 1'b1;
      power_next.mclk_buf_en = 1'b1;
      power_next.control_en = 1'b1;
      power_next.ref_input_buf_en = men | aen;
      power_next.ref_clk_buf_en = sleep_ctl & (men | aen);
      power_next.main_vco_input_en = sleep_ctl & men;
      power_next.aux_div_buf_en = sleep_ctl & aen;
      power_next.main_pd_en = sleep_ctl & men;
      power_next.aux_pd_en = sleep_ctl & aen;
      power_next.lock_detect_en = sleep_ctl & (men | aen);
      power_next.transmit_offset_en = sleep_ctl & ol_en;
      power_next.modulator_en = sleep_ctl & ol_en;
      power_next.vga_en = sleep_ctl & ol_en;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         main_cfg <= '0;
         misc_cfg <= '0;
         power <= '0;
      end
      else
      begin
         main_cfg <= main_next;
         misc_cfg <= cfg_next;
         power <= power_next;
      end
   end

   // ****************************************
   // APB slave
   // ****************************************
   logic access, mapped;
   logic [31:0] rd_mux;
   assign access = psel & penable;
   assign pready = 1'b1;

   always_comb
   begin
      mapped = 1'b1;
      rd_mux = 32'h00000000;
      if (paddr == REG_CTRL)
         rd_mux = {31'h00000000, port_en_reg};
      else if (paddr == REG_STATUS)
         rd_mux = {27'h0000000, word_addr, state_reg == ST_WAIT_SYNC};
      else if (paddr == REG_AWORD)
         rd_mux = {9'h000, a_work_reg};
      else if (paddr == REG_BWORD)
         rd_mux = {16'h0000, kind_work_reg, boost_reg, pump_work_reg};
      else if (paddr == REG_CWORD)
         rd_mux = {13'h0000, c_reg};
      else if (paddr == REG_DWORD)
         rd_mux = {14'h0000, d_reg};
      else if (paddr == REG_GWORD)
         rd_mux = {20'h00000, g_reg};
      else if (paddr == REG_EWORD)
         rd_mux = {13'h0000, e_reg};
      else
         mapped = 1'b0;
   end

   assign pslverr = access & ~mapped;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         port_en_reg <= CTRL_RESET;
      else if (access && pwrite && paddr == REG_CTRL)
         port_en_reg <= pwdata[0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel && !penable && !pwrite)
         prdata <= rd_mux;
   end

   // ****************************************
   // Assertions
   // ****************************************
   sequence a_latched;
      hit_a && state_reg == ST_IDLE;
   endsequence
   sequence no_sync_two;
      (!sync_on)[*2];
   endsequence

   shift_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_rise && !latch_sync_reg[1] |=> shift_reg[23] == $past(data_sync_reg[1]))
      else $error("serial bit not captured");
   ref_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      hit_d |=> d_reg == $past(shift_reg[17:0]))
      else $error("reference word not loaded");
   main_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
      a_latched ##1 no_sync_two |=> $stable(a_work_reg) && state_reg == ST_WAIT_SYNC)
      else $error("main word loaded without sync");
   stage_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_WAIT_SYNC && sync_on && !hit_a
      |=> pump_work_reg == $past(pump_stage_reg) && state_reg == ST_IDLE)
      else $error("staged pump data not copied");
   test_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      hit_d |=> e_reg == 19'h00000)
      else $error("test word not cleared");
   unknown_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
      load && !shift_reg[23] && !(hit_b || hit_c || hit_d || hit_e || hit_g)
      |=> $stable(c_reg) && $stable(d_reg) && $stable(g_reg) && $stable(e_reg))
      else $error("unknown word changed state");
   sleep_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn) && !sleep_ctl && !ol_en && !men && !aen
      |=> power == 13'b1110000000000)
      else $error("sleep mode enables wrong");
   transmit_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      sleep_ctl && ol_en && men && aen |=> &power)
      else $error("transmit mode not fully enabled");
   offset_div_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn) |=> misc_cfg.offset_loop_div
      == ($past(g_reg[OLDIV_POS + 1]) ? 4'h8 : 4'h6) + {3'h0, $past(g_reg[OLDIV_POS])})
      else $error("offset divide wrong");

endmodule // spp_serial_port

// [tb/spp_host_model.sv]
`timescale 1ns/10ps
// ****************************************
// Host side of the three-wire programming port
// ****************************************
module spp_host_model
(
   input wire logic pclk,
   output logic ser_clk,
   output logic ser_data,
   output logic load_latch
);
   // The link clock idles low between words; the latch idles high.
   initial
   begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      load_latch = 1'b1;
   end

   // Half is the half period in system clocks, so 4 gives an 800 ns link clock.
   task automatic send_word(input logic [23:0] word, input int half);
      @(posedge pclk);
      load_latch <= 1'b0;
      for (int i = 0; i < 24; i++)
      begin
         ser_data <= word[i];
         repeat (half) @(posedge pclk);
         ser_clk <= 1'b1;
         repeat (half) @(posedge pclk);
         ser_clk <= 1'b0;
      end
      // The latch rises half a period after the last bit; the data line is
      // left showing the inverse so a stale level cannot pass for a good one.
      load_latch <= 1'b1;
      ser_data <= ~word[23];
   endtask
endmodule // spp_host_model

// [tb/serial_program_power_mode_tb.sv]
`timescale 1ns/10ps
module serial_program_power_mode_tb
   import spp_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic ser_clk, ser_data, load_latch, main_sync;
   logic [12:0] exp_power;
   logic [7:0] old_pump;
   logic [11:0] old_first;
   spp_main_t main_cfg, main_snap;
   spp_cfg_t misc_cfg, misc_snap;
   spp_power_t power;
   int errors, check_count, cycles;

   spp_serial_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ser_clk(ser_clk), .ser_data(ser_data), .load_latch(load_latch),
      .main_sync(main_sync), .main_cfg(main_cfg), .misc_cfg(misc_cfg), .power(power));

   spp_host_model host (.pclk(pclk), .ser_clk(ser_clk), .ser_data(ser_data),
      .load_latch(load_latch));

   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // About 40 words of 200 cycles each; the ceiling leaves two and a half times that.
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         give_verdict();
      end
   end

   // ****************************************
   // Access tasks
   // ****************************************
   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
      begin
         $display("STATUS OK");
      end
      else
      begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic ok, input string what);
      check_count++;
      if (ok !== 1'b1)
      begin
         errors++;
         $display("BAD %0t %s", $time, what);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic put(input logic [23:0] w, input int half = 4);
      host.send_word(w, half);
      repeat (10) @(posedge pclk);
   endtask

   // The latch stays high across the pulse so the pending word may load.
   task automatic sync_pulse();
      main_sync <= 1'b1;
      repeat (4) @(posedge pclk);
      main_sync <= 1'b0;
      repeat (10) @(posedge pclk);
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      main_sync = 1'b0;
      presetn = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(power === 13'h1c00, "sleep after reset");
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd === 32'h1 && err === 1'b0, "ctrl reset");
      apb(1'b0, 8'h20, 32'h0);
      chk(err === 1'b1 && rd === 32'h0, "unmapped read");
      for (int m = 0; m < 4; m++)
      begin
         put({4'h3, 2'b00, {2{m != 0}}, 4'h0, 12'h010});
         put({4'h5, 8'h00, m != 0, m[0], m >= 2, m[1:0], 7'h2a});
         exp_power = (m == 0) ? 13'h1c00 : (m == 1) ? 13'h1ff8 : 13'h1fff;
         chk(power === exp_power, "power mode");
         chk(misc_cfg.offset_loop_div === 4'h6 + 4'(m), "offset div");
         chk(misc_cfg.digital_mode === m[0], "mode");
         chk(misc_cfg.driver_low_current === !m[0], "driver");
         chk(misc_cfg.vga_power_level === 7'h2a, "vga");
      end
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd[4:1] === 4'h5, "shift address");
      put({4'h5, 13'h0, 7'h2a});
      for (int k = 1; k < 3; k++)
      begin
         put({4'h3, 2'b00, k[1:0], 4'h0, 12'h010});
         chk(power.ref_input_buf_en === 1'b1, "ref buffer");
         chk(power.main_pd_en === 1'b0, "asleep");
      end
      for (int c = 0; c < 4; c++)
      begin
         put({4'h3, 4'h0, 2'(3 - c), 2'(c), 12'h123 + 12'(c)});
         chk(misc_cfg.main_postscale === (4'h1 << c), "main post");
         chk(misc_cfg.aux_postscale === (4'h8 >> c), "aux post");
         chk(misc_cfg.ref_divide_ratio === 12'h123 + 12'(c), "ref ratio");
      end
      put({4'h4, 1'b0, 19'h5a5a5});
      chk(misc_cfg.test_bits === 19'h5a5a5, "test word");
      put({4'h3, 8'h00, 12'h0ff});
      chk(misc_cfg.test_bits === 19'h0, "test cleared");
      put({4'h2, 1'b0, 5'h00, 13'h1abc, 1'b0});
      chk(misc_cfg.aux_divide_ratio === 13'h1abc, "aux ratio");
      old_pump = 8'h00;
      old_first = 12'h000;
      for (int k = 0; k < 4; k++)
      begin
         put({4'h1, 4'h0, k[1:0], 4'h9, k[1:0], 8'h30 + 8'(k)});
         chk(misc_cfg.proportional_boost === k[1:0], "boost");
         chk(misc_cfg.integral_boost === 4'h9, "int boost");
         chk(main_cfg.pump_current_factor === old_pump, "pump staged");
         put({4'h2, 1'b0, 4'h0, k[0], 13'h0040, 1'b0});
         // The last word goes slowly to show the port tolerates a slower host.
         put({1'b1, 3'h5, 8'ha7, 12'h800 + 12'(k)}, (k == 3) ? 6 : 4);
         repeat (20) @(posedge pclk);
         apb(1'b0, REG_STATUS, 32'h0);
         chk(rd[0] === 1'b1, "pending");
         chk(main_cfg.first_ratio_count === old_first, "main waits");
         sync_pulse();
         chk(main_cfg.first_ratio_count === 12'h800 + 12'(k), "main load");
         chk(main_cfg.pump_current_factor === 8'h30 + 8'(k), "pump load");
         chk(main_cfg.two_modulus === k[0], "kind");
         chk(main_cfg.second_ratio_count === (k[0] ? 8'ha7 : 8'h07), "second");
         chk(main_cfg.third_ratio_count === (k[0] ? 4'h0 : 4'ha), "third");
         chk(main_cfg.frac_increment === 4'h5, "increment");
         chk(main_cfg.frac_modulus === (k[0] ? 5'h08 : 5'h05), "modulus");
         chk(main_cfg.main_divide_ratio === 18'h00000, "std ratio");
         old_pump = 8'h30 + 8'(k);
         old_first = 12'h800 + 12'(k);
      end
      put({4'h2, 1'b0, 5'h10, 13'h0040, 1'b1});
      put({1'b1, 1'b0, 4'hb, 18'h2abcd});
      sync_pulse();
      chk(main_cfg.enhanced === 1'b1, "enhanced");
      chk(main_cfg.main_divide_ratio === 18'h2abcd, "enh ratio");
      chk(main_cfg.frac_increment === 4'hb, "enh increment");
      chk(main_cfg.frac_modulus === 5'h10, "enh modulus");
      apb(1'b0, REG_AWORD, 32'h0);
      chk(rd === 32'h002eabcd && err === 1'b0, "main word read");
      apb(1'b0, REG_CWORD, 32'h0);
      chk(rd === 32'h00040081 && err === 1'b0, "aux word read");
      for (int a = 0; a < 8; a++)
      begin
         if (a == 0 || a > 5)
         begin
            main_snap = main_cfg;
            misc_snap = misc_cfg;
            put({4'(a), 20'hfffff});
            sync_pulse();
            chk(main_cfg === main_snap && misc_cfg === misc_snap, "unknown");
         end
      end
      apb(1'b1, REG_CTRL, 32'h0);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd === 32'h0, "ctrl write");
      put({4'h5, 13'h0, 7'h11});
      chk(misc_cfg.vga_power_level === 7'h2a, "port off");
      apb(1'b1, REG_CTRL, 32'h1);
      put({4'h5, 13'h0, 7'h11});
      chk(misc_cfg.vga_power_level === 7'h11, "port on");
      give_verdict();
   end
endmodule // serial_program_power_mode_tb
